// File: ts_time_pkg.sv
// shared constants and types for the timestamp-A time holding registers
package ts_time_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] TIME_LOW_OFFSET = 12'h000;
  localparam logic [11:0] TIME_HIGH_OFFSET = 12'h004;
  localparam logic [11:0] CONTROL_OFFSET = 12'h008;
  localparam logic [11:0] STATUS_OFFSET = 12'h00C;

  // ==========================================================
  // field positions
  localparam int SEC_TENS_LSB = 12;
  localparam int SEC_UNITS_LSB = 8;
  localparam int HRS_TENS_LSB = 12;
  localparam int HRS_UNITS_LSB = 8;
  localparam int MIN_TENS_LSB = 4;
  localparam int MIN_UNITS_LSB = 0;
  localparam int ENABLE_BIT = 0;

  // ==========================================================
  // legal digit limits
  localparam logic [3:0] SEC_TENS_MAX = 4'h5;
  localparam logic [3:0] UNITS_MAX = 4'h9;
  localparam logic [3:0] HRS_TENS_MAX = 4'h2;
  localparam logic [3:0] MIN_TENS_MAX = 4'h5;

  // ==========================================================
  // reset values
  localparam logic [15:0] TIME_RESET = 16'h0000;
  localparam logic ENABLE_RESET = 1'b0;

  // ==========================================================
  // register images
  typedef struct packed {
    logic [2:0] seconds_tens_digit;
    logic [3:0] seconds_units_digit;
  } time_low_type;

  typedef struct packed {
    logic [1:0] hours_tens_digit;
    logic [3:0] hours_units_digit;
    logic [2:0] minutes_tens_digit;
    logic [3:0] minutes_units_digit;
  } time_high_type;

endpackage : ts_time_pkg

// File: timestamp_a_time_regs.sv
// timestamp-A time holding registers behind an APB slave
`timescale 1ns/1ns

// Summary of operation
// - seconds tens digit in bits 14-12
// - seconds units digit in bits 11-8
// - low register bit 15 reads zero
// - low register bits 7-0 read zero
// - disabled: plain storage, only power-on clears
module timestamp_a_time_regs
  import ts_time_pkg::*;
(
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_on_reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // stored time towards neighbouring logic
  output time_low_type time_low,
  output time_high_type time_high,
  output logic timestamp_a_enable
);

  // ==========================================================
  // helpers
  function automatic logic digit_ok(input logic [3:0] digit, input logic [3:0] limit);
    digit_ok = (digit <= limit);
  endfunction : digit_ok

  function automatic logic [15:0] low_image(input time_low_type r);
    logic [15:0] v;
    v = 16'h0000;
    v[SEC_TENS_LSB +: 3] = r.seconds_tens_digit;
    v[SEC_UNITS_LSB +: 4] = r.seconds_units_digit;
    low_image = v;
  endfunction : low_image

  function automatic logic [15:0] high_image(input time_high_type r);
    logic [15:0] v;
    v = 16'h0000;
    v[HRS_TENS_LSB +: 2] = r.hours_tens_digit;
    v[HRS_UNITS_LSB +: 4] = r.hours_units_digit;
    v[MIN_TENS_LSB +: 3] = r.minutes_tens_digit;
    v[MIN_UNITS_LSB +: 4] = r.minutes_units_digit;
    high_image = v;
  endfunction : high_image

  // ==========================================================
  // bus decode
  time_low_type time_low_ff;
  time_high_type time_high_ff;
  logic enable_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic access;
  logic wr_en;
  logic hit_low;
  logic hit_high;
  logic hit_ctrl;
  logic hit_stat;
  logic mapped;
  logic [3:0] valid_flags;
  logic [31:0] nxt_prdata;

  // zero wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign access = psel & penable;
  assign wr_en = access & pwrite;
  assign hit_low = (paddr == TIME_LOW_OFFSET);
  assign hit_high = (paddr == TIME_HIGH_OFFSET);
  assign hit_ctrl = (paddr == CONTROL_OFFSET);
  assign hit_stat = (paddr == STATUS_OFFSET);
  assign mapped = hit_low | hit_high | hit_ctrl | hit_stat;

  // ==========================================================
  // time storage, cleared only by power-on reset
  // bus reset is left out on purpose so pin and watchdog resets keep contents
  // while enabled the capture logic owns the registers, so software may not write
  always_ff @(posedge pclk or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      time_low_ff <= time_low_type'(TIME_RESET[6:0]);
    end else if (wr_en && hit_low && !enable_ff && pstrb[1]) begin
      time_low_ff.seconds_tens_digit <= pwdata[SEC_TENS_LSB +: 3];
      time_low_ff.seconds_units_digit <= pwdata[SEC_UNITS_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      time_high_ff <= time_high_type'(TIME_RESET[12:0]);
    end else if (wr_en && hit_high && !enable_ff) begin
      if (pstrb[1]) begin
        time_high_ff.hours_tens_digit <= pwdata[HRS_TENS_LSB +: 2];
        time_high_ff.hours_units_digit <= pwdata[HRS_UNITS_LSB +: 4];
      end
      if (pstrb[0]) begin
        time_high_ff.minutes_tens_digit <= pwdata[MIN_TENS_LSB +: 3];
        time_high_ff.minutes_units_digit <= pwdata[MIN_UNITS_LSB +: 4];
      end
    end
  end

  // ==========================================================
  // enable control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= ENABLE_RESET;
    end else if (wr_en && hit_ctrl && pstrb[0]) begin
      enable_ff <= pwdata[ENABLE_BIT];
    end
  end

  // ==========================================================
  // read path and error answer
  assign valid_flags = {
    digit_ok({1'b0, time_low_ff.seconds_tens_digit}, SEC_TENS_MAX) &
      digit_ok(time_low_ff.seconds_units_digit, UNITS_MAX),
    digit_ok({2'b00, time_high_ff.hours_tens_digit}, HRS_TENS_MAX) &
      digit_ok(time_high_ff.hours_units_digit, UNITS_MAX),
    digit_ok({1'b0, time_high_ff.minutes_tens_digit}, MIN_TENS_MAX) &
      digit_ok(time_high_ff.minutes_units_digit, UNITS_MAX),
    enable_ff
  };

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (hit_low) begin
      nxt_prdata = {16'h0000, low_image(time_low_ff)};
    end else if (hit_high) begin
      nxt_prdata = {16'h0000, high_image(time_high_ff)};
    end else if (hit_ctrl) begin
      nxt_prdata = {31'h0000_0000, enable_ff};
    end else if (hit_stat) begin
      nxt_prdata = {28'h000_0000, valid_flags};
    end
  end

  // data is registered in the setup cycle so it stands during the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= psel & !penable & !mapped;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff & access;
  assign time_low = time_low_ff;
  assign time_high = time_high_ff;
  assign timestamp_a_enable = enable_ff;

  // ==========================================================
  // checks
  a_low_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && hit_low) |-> (prdata[31:15] == 17'h0 && prdata[7:0] == 8'h00))
    else $error("low register reserved bits not zero");

  a_low_unused_bits: assert property (@(posedge pclk) disable iff (!power_on_reset_n)
    (wr_en && hit_low && !enable_ff && pstrb[1]) |=>
      (low_image(time_low_ff) == {1'b0, $past(pwdata[14:8]), 8'h00}))
    else $error("low register write mismatch");

  a_sec_tens_field: assert property (@(posedge pclk) disable iff (!power_on_reset_n)
    (wr_en && hit_low && !enable_ff && pstrb[1]) |=>
      (time_low_ff.seconds_tens_digit == $past(pwdata[14:12])))
    else $error("seconds tens digit not stored");

  a_sec_units_rd: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_low) |=>
      (prdata[11:8] == $past(time_low_ff.seconds_units_digit)))
    else $error("seconds units digit read mismatch");

  a_storage_kept: assert property (@(posedge pclk) disable iff (!power_on_reset_n)
    (!(wr_en && (hit_low || hit_high))) |=>
      ($stable(time_low_ff) && $stable(time_high_ff)))
    else $error("storage changed without a write");

  a_enabled_locked: assert property (@(posedge pclk) disable iff (!power_on_reset_n)
    enable_ff |=> $stable(time_low_ff) && $stable(time_high_ff))
    else $error("storage written while enabled");

  a_high_layout: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_high) |=>
      (prdata[31:14] == 18'h0 && prdata[7] == 1'b0 &&
       prdata[3:0] == $past(time_high_ff.minutes_units_digit)))
    else $error("high register layout mismatch");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !mapped) ##1 (psel && penable) |-> pslverr)
    else $error("unmapped access gave no error");

  // ==========================================================
  // bus handshake checks
  // zero wait states: a master that waits on ready must never stall here
  a_ready_always: assert property (@(posedge pclk) disable iff (!presetn)
    psel |-> pready)
    else $error("ready dropped during a transfer");

  a_err_only_access: assert property (@(posedge pclk) disable iff (!presetn)
    !access |-> !pslverr)
    else $error("error flag outside an access cycle");

  a_mapped_no_err: assert property (@(posedge pclk) disable iff (!presetn)
    (access && mapped) |-> !pslverr)
    else $error("error flag on a mapped register");

  a_unmapped_data: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && !mapped) |-> (prdata == 32'h0000_0000))
    else $error("unmapped read returned data");

  // ==========================================================
  // read layout checks
  // data is loaded in the setup cycle, so fields are held against that edge
  a_high_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && hit_high) |-> (prdata[31:14] == 18'h0 && prdata[7] == 1'b0))
    else $error("high register reserved bits not zero");

  a_ctrl_layout: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && hit_ctrl) |-> (prdata[31:1] == 31'h0))
    else $error("control register upper bits not zero");

  a_stat_layout: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && hit_stat) |-> (prdata[31:4] == 28'h0))
    else $error("status register upper bits not zero");

  a_stat_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_stat) |=> (prdata[0] == $past(enable_ff)))
    else $error("status enable bit mismatch");

  a_sec_tens_rd: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_low) |=>
      (prdata[14:12] == $past(time_low_ff.seconds_tens_digit)))
    else $error("seconds tens digit read mismatch");

  a_hrs_tens_rd: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_high) |=>
      (prdata[13:12] == $past(time_high_ff.hours_tens_digit)))
    else $error("hours tens digit read mismatch");

  a_hrs_units_rd: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_high) |=>
      (prdata[11:8] == $past(time_high_ff.hours_units_digit)))
    else $error("hours units digit read mismatch");

  a_min_tens_rd: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_high) |=>
      (prdata[6:4] == $past(time_high_ff.minutes_tens_digit)))
    else $error("minutes tens digit read mismatch");

  // ==========================================================
  // write checks
  // lane strobes gate whole bytes; a cleared lane must leave its digits alone
  a_sec_units_field: assert property (@(posedge pclk) disable iff (!power_on_reset_n)
    (wr_en && hit_low && !enable_ff && pstrb[1]) |=>
      (time_low_ff.seconds_units_digit == $past(pwdata[11:8])))
    else $error("seconds units digit not stored");

  a_low_lane_off: assert property (@(posedge pclk) disable iff (!power_on_reset_n)
    (wr_en && hit_low && !pstrb[1]) |=> $stable(time_low_ff))
    else $error("low register changed with lane off");

  a_hrs_field: assert property (@(posedge pclk) disable iff (!power_on_reset_n)
    (wr_en && hit_high && !enable_ff && pstrb[1]) |=>
      (time_high_ff.hours_tens_digit == $past(pwdata[13:12]) &&
       time_high_ff.hours_units_digit == $past(pwdata[11:8])))
    else $error("hours digits not stored");

  a_min_field: assert property (@(posedge pclk) disable iff (!power_on_reset_n)
    (wr_en && hit_high && !enable_ff && pstrb[0]) |=>
      (time_high_ff.minutes_tens_digit == $past(pwdata[6:4]) &&
       time_high_ff.minutes_units_digit == $past(pwdata[3:0])))
    else $error("minutes digits not stored");

  a_high_lane1_off: assert property (@(posedge pclk) disable iff (!power_on_reset_n)
    (wr_en && hit_high && !pstrb[1]) |=>
      ($stable(time_high_ff.hours_tens_digit) && $stable(time_high_ff.hours_units_digit)))
    else $error("hours changed with lane off");

  a_high_lane0_off: assert property (@(posedge pclk) disable iff (!power_on_reset_n)
    (wr_en && hit_high && !pstrb[0]) |=>
      ($stable(time_high_ff.minutes_tens_digit) && $stable(time_high_ff.minutes_units_digit)))
    else $error("minutes changed with lane off");

  // enable sits on the bus reset, unlike the time storage
  a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_ctrl && pstrb[0]) |=> (enable_ff == $past(pwdata[ENABLE_BIT])))
    else $error("enable bit not stored");

  a_enable_kept: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && hit_ctrl && pstrb[0]) |=> $stable(enable_ff))
    else $error("enable bit changed without a write");

endmodule : timestamp_a_time_regs

// File: timestamp_a_time_regs_tb.sv
// self-checking bench for the timestamp-A time holding registers
`timescale 1ns/1ns
module timestamp_a_time_regs_tb
  import ts_time_pkg::*;
();
  // ==========================================================
  // signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic power_on_reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  time_low_type time_low;
  time_high_type time_high;
  logic timestamp_a_enable;
  logic [31:0] rnd = 32'hB481;
  logic [32:0] lo_e = 33'h0;
  logic [32:0] hi_e = 33'h0;
  logic [32:0] exp_q[$];
  int mismatches = 0;
  int cmp_count = 0;

  always #2 pclk = ~pclk;

  timestamp_a_time_regs DUT (
    .pclk(pclk), .presetn(presetn), .power_on_reset_n(power_on_reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .time_low(time_low), .time_high(time_high),
    .timestamp_a_enable(timestamp_a_enable)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic stop_test();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // idle edge first, so strobes never change twice in one time step
  task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwdata <= d;
    pwrite <= w;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(a, d, 1'b1, s);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(a, 32'h0, 1'b0, 4'hF);
  endtask : rd

  // bus or power-on reset pulse, held three cycles
  task automatic pulse_reset(input logic por);
    @(posedge pclk);
    presetn <= 1'b0;
    if (por) power_on_reset_n <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    power_on_reset_n <= 1'b1;
  endtask : pulse_reset

  // ==========================================================
  // read monitor: {pslverr, prdata} against oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) chk(33'h1FFFFFFFF, 33'h0);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    power_on_reset_n <= 1'b1;
    rd(TIME_LOW_OFFSET, 33'h0);
    rd(TIME_HIGH_OFFSET, 33'h0);
    wr(TIME_LOW_OFFSET, 32'hFFFFFFFF, 4'hF);
    rd(TIME_LOW_OFFSET, 33'h7F00);
    chk({26'h0, time_low}, 33'h7F);
    // seconds digits now illegal, hours and minutes still legal, disabled
    rd(STATUS_OFFSET, 33'h6);
    wr(TIME_HIGH_OFFSET, 32'hFFFFFFFF, 4'hF);
    rd(TIME_HIGH_OFFSET, 33'h3F7F);
    // lane 0 only: minutes cleared, hours kept
    wr(TIME_HIGH_OFFSET, 32'h0, 4'h1);
    rd(TIME_HIGH_OFFSET, 33'h3F00);
    chk({20'h0, time_high}, 33'h1F80);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      lo_e = {1'b0, rnd & 32'h00007F00};
      wr(TIME_LOW_OFFSET, rnd, 4'hF);
      rd(TIME_LOW_OFFSET, lo_e);
      rnd = lfsr(rnd);
      hi_e = {1'b0, rnd & 32'h00003F7F};
      wr(TIME_HIGH_OFFSET, rnd, 4'hF);
      rd(TIME_HIGH_OFFSET, hi_e);
    end
    pulse_reset(1'b0);
    rd(TIME_LOW_OFFSET, lo_e);
    rd(TIME_HIGH_OFFSET, hi_e);
    // enabled: capture owns the time, software writes dropped
    wr(CONTROL_OFFSET, 32'h1, 4'hF);
    rd(CONTROL_OFFSET, 33'h1);
    chk({32'h0, timestamp_a_enable}, 33'h1);
    wr(TIME_LOW_OFFSET, 32'h0, 4'hF);
    rd(TIME_LOW_OFFSET, lo_e);
    pulse_reset(1'b0);
    rd(CONTROL_OFFSET, 33'h0);
    rd(12'h010, 33'h100000000);
    pulse_reset(1'b1);
    rd(TIME_LOW_OFFSET, 33'h0);
    rd(TIME_HIGH_OFFSET, 33'h0);
    chk({20'h0, time_high}, 33'h0);
    rd(STATUS_OFFSET, 33'hE);
    chk({32'h0, pready}, 33'h1);
    @(posedge pclk);
    stop_test();
  end
endmodule : timestamp_a_time_regs_tb
